// file: design/dma_evt_params.svh
// constants for the dma channel event and completion interrupt controller
`ifndef DMA_EVT_PARAMS_SVH
`define DMA_EVT_PARAMS_SVH
`define CH_N        32
`define QCH_N       8
`define ALL_N       40
`define IDX_W       6
`define CODE_W      5
`define REG_N       2
`define HIST_DEPTH  4
`define HIST_IDX_W  2
`define LINK_W      16
`define NULL_LINK   16'hFFFF
`define KEEP_OFF    1'h0
`define ST_IDLE_V   2'h1
`define ST_OFFER_V  2'h2
`endif

// file: design/dma_evt_pkg.sv
// types shared by the dma event and completion interrupt controller
`include "dma_evt_params.svh"
package dma_evt_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = `ST_IDLE_V,
    ST_OFFER = `ST_OFFER_V
  } svc_state_e;
  typedef logic [`IDX_W-1:0] chan_idx_t;
endpackage

// file: design/hist_if.sv
// carrier between the controller and its serviced-event history
`timescale 1ns/1ps
`default_nettype none
`include "dma_evt_params.svh"
interface hist_if;
  logic                   push;
  dma_evt_pkg::chan_idx_t ch;
  logic [`HIST_IDX_W-1:0] rd_idx;
  dma_evt_pkg::chan_idx_t rd_ch;
  logic                   rd_vld;
  modport prod  (output push, ch, rd_idx, input rd_ch, rd_vld);
  modport store (input push, ch, rd_idx, output rd_ch, rd_vld);
endinterface
`default_nettype wire

// file: design/w1_bits.sv
// bank of flags changed only by write-1 set and write-1 clear strobes
`timescale 1ns/1ps
`default_nettype none
module w1_bits #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // write-1 strobes
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // flags
  output logic      [W-1:0] q_o
);
  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      q_o <= '0;
    else
      q_o <= set_i | (q_o & ~clr_i);
  end
endmodule
`default_nettype wire

// file: design/evt_history.sv
// ring of recently serviced channels, kept readable after use
`timescale 1ns/1ps
`default_nettype none
`include "dma_evt_params.svh"
module evt_history (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // producer side
  hist_if.store     h
);
  dma_evt_pkg::chan_idx_t ent_q [`HIST_DEPTH];
  logic [`HIST_DEPTH-1:0] vld_q;
  logic [`HIST_IDX_W-1:0] wp_q;

  // entries are never consumed, only overwritten when the ring wraps
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wp_q  <= '0;
      vld_q <= '0;
      for (int i = 0; i < `HIST_DEPTH; i++)
        ent_q[i] <= '0;
    end
    else if (h.push)
    begin
      ent_q[wp_q] <= h.ch;
      vld_q[wp_q] <= 1'b1;
      wp_q        <= wp_q + 2'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      h.rd_ch  <= '0;
      h.rd_vld <= 1'b0;
    end
    else
    begin
      h.rd_ch  <= ent_q[h.rd_idx];
      h.rd_vld <= vld_q[h.rd_idx];
    end
  end
endmodule
`default_nettype wire

// file: design/dma_event_irq_ctl.sv
// event acceptance, null-set error flags and completion interrupts of a dma channel controller
`timescale 1ns/1ps
`default_nettype none
`include "dma_evt_params.svh"
module dma_event_irq_ctl (
  // clock and reset
  input  wire logic                                 mclk_i,
  input  wire logic                                 rst_n_i,
  // event sources and write-1 ports
  input  wire logic [`CH_N-1:0]                     periph_evt_i,
  input  wire logic [`CH_N-1:0]                     event_set_port_i,
  input  wire logic [`CH_N-1:0]                     event_latch_clear_port_i,
  input  wire logic [`CH_N-1:0]                     enable_mask_set_port_i,
  input  wire logic [`CH_N-1:0]                     enable_mask_clear_port_i,
  input  wire logic [`QCH_N-1:0]                    quick_enable_set_i,
  input  wire logic [`QCH_N-1:0]                    quick_enable_clear_i,
  input  wire logic [`CH_N-1:0]                     secondary_clear_i,
  input  wire logic [`CH_N-1:0]                     missed_clear_i,
  input  wire logic [`QCH_N-1:0]                    quick_secondary_clear_i,
  input  wire logic [`QCH_N-1:0]                    quick_missed_clear_i,
  input  wire logic [`CH_N-1:0]                     irq_enable_set_i,
  input  wire logic [`CH_N-1:0]                     irq_enable_clear_i,
  input  wire logic [`CH_N-1:0]                     pending_clear_port_i,
  // parameter set writes by software
  input  wire logic [`CH_N-1:0]                     set_write_i,
  input  wire logic [`QCH_N-1:0]                    quick_set_write_i,
  // shadow regions
  input  wire logic [`REG_N-1:0][`CH_N-1:0]         dma_region_access_mask_i,
  input  wire logic [`REG_N-1:0][`QCH_N-1:0]        quick_region_access_mask_i,
  input  wire logic                                 shd_wr_i,
  input  wire logic                                 shd_region_i,
  input  wire logic [`CH_N-1:0]                     shd_event_set_i,
  input  wire logic [`CH_N-1:0]                     shd_latch_clear_i,
  input  wire logic [`CH_N-1:0]                     shd_pending_clear_i,
  input  wire logic [`QCH_N-1:0]                    shd_quick_enable_set_i,
  output logic      [`CH_N-1:0]                     shd_event_latch_o,
  output logic      [`CH_N-1:0]                     shd_pending_o,
  // transfer request hand-off
  output logic                                      svc_valid_o,
  output dma_evt_pkg::chan_idx_t                    svc_ch_o,
  input  wire logic                                 svc_ready_i,
  input  wire logic                                 sub_keep_i,
  input  wire logic [`LINK_W-1:0]                   sub_link_i,
  input  wire logic                                 sub_early_i,
  input  wire logic                                 sub_final_i,
  input  wire logic                                 sub_final_completion_irq_en_i,
  input  wire logic                                 sub_intermediate_completion_irq_en_i,
  input  wire logic                                 sub_chain_en_i,
  input  wire logic [`CODE_W-1:0]                   sub_code_i,
  input  wire logic                                 sub_bypass_i,
  // completions from the transfer controller
  input  wire logic                                 cmp_valid_i,
  input  wire logic                                 cmp_final_i,
  input  wire logic                                 cmp_final_completion_irq_en_i,
  input  wire logic                                 cmp_intermediate_completion_irq_en_i,
  input  wire logic                                 cmp_chain_en_i,
  input  wire logic [`CODE_W-1:0]                   cmp_code_i,
  input  wire logic                                 xfer_busy_i,
  // status and interrupts
  output logic      [`CH_N-1:0]                     event_latch_o,
  output logic      [`CH_N-1:0]                     event_enable_mask_o,
  output logic      [`QCH_N-1:0]                    quick_channel_enable_mask_o,
  output logic      [`CH_N-1:0]                     secondary_event_flags_o,
  output logic      [`CH_N-1:0]                     event_missed_flags_o,
  output logic      [`QCH_N-1:0]                    quick_secondary_flags_o,
  output logic      [`QCH_N-1:0]                    quick_missed_flags_o,
  output logic      [`CH_N-1:0]                     completion_pending_flags_o,
  output logic      [`CH_N-1:0]                     completion_irq_enable_mask_o,
  output logic                                      cmp_irq_o,
  output logic      [`REG_N-1:0]                    region_irq_o,
  output logic                                      err_irq_o,
  output logic                                      cc_busy_o,
  output logic                                      pwr_idle_o,
  // serviced-event history
  input  wire logic [`HIST_IDX_W-1:0]               hist_idx_i,
  output dma_evt_pkg::chan_idx_t                    hist_ch_o,
  output logic                                      hist_vld_o
);
  function automatic logic [`ALL_N-1:0] onehot(input dma_evt_pkg::chan_idx_t idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction

  function automatic dma_evt_pkg::chan_idx_t first_set(input logic [`ALL_N-1:0] v);
    first_set = '0;
    for (int i = `ALL_N - 1; i >= 0; i--)
      if (v[i])
        first_set = dma_evt_pkg::chan_idx_t'(i);
  endfunction

  function automatic logic [`CH_N-1:0] code_bit(input logic [`CODE_W-1:0] code);
    logic [`ALL_N-1:0] full;
    full = onehot({1'b0, code});
    code_bit = full[`CH_N-1:0];
  endfunction

  function automatic logic [`QCH_N-1:0] q_pick_bit(input dma_evt_pkg::chan_idx_t idx);
    logic [`ALL_N-1:0] full;
    full = onehot(idx);
    q_pick_bit = full[`ALL_N-1:`CH_N];
  endfunction

  dma_evt_pkg::svc_state_e st_q;
  dma_evt_pkg::chan_idx_t  pick_q;
  logic [`CH_N-1:0]  er_q, eer_q, ser_q, emr_q, trg_q, null_q, ipr_q, ier_q;
  logic [`QCH_N-1:0] quick_channel_enable_mask_q, quick_secondary_flags_q, quick_missed_flags_q, qtrg_q, qnull_q, qreload_q;
  logic [`CH_N-1:0]  shd_mask, shd_set, chain, man_arr, en_arr, null_now, arr_err, er_clr;
  logic [`CH_N-1:0]  ipr_set, ipr_clr, d_elig, d_pick;
  logic [`QCH_N-1:0] qarr, qnull_now, qerr, q_elig, q_pick;
  logic [`ALL_N-1:0] elig, pick_vec;
  logic              any_elig, take, accept, null_sub;
  hist_if            hq ();

  assign shd_mask  = dma_region_access_mask_i[shd_region_i];
  assign shd_set   = shd_wr_i ? (shd_event_set_i & shd_mask) : '0;
  assign chain     = ((accept && sub_early_i && sub_chain_en_i) ? code_bit(sub_code_i) : '0)
                   | ((cmp_valid_i && cmp_chain_en_i) ? code_bit(cmp_code_i) : '0);
  assign man_arr   = event_set_port_i | shd_set | chain;
  assign en_arr    = (periph_evt_i & eer_q) | man_arr;
  // a fresh software write makes the set live again in the same cycle
  assign null_now  = null_q & ~set_write_i;
  assign arr_err   = en_arr & null_now;
  assign er_clr    = event_latch_clear_port_i | d_pick
                   | (shd_wr_i ? (shd_latch_clear_i & shd_mask) : '0);
  assign qarr      = (quick_set_write_i | qreload_q) & quick_channel_enable_mask_q;
  assign qnull_now = qnull_q & ~quick_set_write_i;
  assign qerr      = qarr & qnull_now;

  w1_bits #(.W(`CH_N)) u_er (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(periph_evt_i & ~(eer_q & null_now)), .clr_i(er_clr), .q_o(er_q));
  w1_bits #(.W(`CH_N)) u_eer (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(enable_mask_set_port_i), .clr_i(enable_mask_clear_port_i), .q_o(eer_q));
  w1_bits #(.W(`CH_N)) u_trg (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(man_arr & ~null_now), .clr_i(d_pick), .q_o(trg_q));
  w1_bits #(.W(`CH_N)) u_ser (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(arr_err), .clr_i(secondary_clear_i), .q_o(ser_q));
  w1_bits #(.W(`CH_N)) u_emr (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(arr_err | (en_arr & ser_q)), .clr_i(missed_clear_i), .q_o(emr_q));
  w1_bits #(.W(`QCH_N)) u_quick_channel_enable_mask (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(quick_enable_set_i | (shd_wr_i ? (shd_quick_enable_set_i
      & quick_region_access_mask_i[shd_region_i]) : '0)),
    .clr_i(quick_enable_clear_i), .q_o(quick_channel_enable_mask_q));
  w1_bits #(.W(`QCH_N)) u_qtrg (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(qarr & ~qnull_now), .clr_i(q_pick), .q_o(qtrg_q));
  w1_bits #(.W(`QCH_N)) u_quick_secondary_flags (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(qerr), .clr_i(quick_secondary_clear_i), .q_o(quick_secondary_flags_q));
  w1_bits #(.W(`QCH_N)) u_quick_missed_flags (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(qerr | (qarr & quick_secondary_flags_q)), .clr_i(quick_missed_clear_i), .q_o(quick_missed_flags_q));
  w1_bits #(.W(`CH_N)) u_ier (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(irq_enable_set_i), .clr_i(irq_enable_clear_i), .q_o(ier_q));
  w1_bits #(.W(`CH_N)) u_ipr (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .set_i(ipr_set), .clr_i(ipr_clr), .q_o(ipr_q));

  assign d_elig   = ((er_q & eer_q) | trg_q) & ~ser_q;
  assign q_elig   = qtrg_q & quick_channel_enable_mask_q & ~quick_secondary_flags_q;
  assign elig     = {q_elig, d_elig};
  assign any_elig = |elig;
  assign take     = (st_q == dma_evt_pkg::ST_IDLE) && any_elig;
  assign pick_vec = take ? onehot(first_set(elig)) : '0;
  assign d_pick   = pick_vec[`CH_N-1:0];
  assign q_pick   = pick_vec[`ALL_N-1:`CH_N];
  assign accept   = (st_q == dma_evt_pkg::ST_OFFER) && svc_ready_i;
  assign null_sub = accept && (sub_keep_i == `KEEP_OFF) && (sub_link_i == `NULL_LINK);

  // the request is held until the transfer controller takes it
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q   <= dma_evt_pkg::ST_IDLE;
      pick_q <= '0;
    end
    else
    begin
      case (st_q)
        dma_evt_pkg::ST_IDLE:
          if (any_elig)
          begin
            pick_q <= first_set(elig);
            st_q   <= dma_evt_pkg::ST_OFFER;
          end
        dma_evt_pkg::ST_OFFER:
          if (svc_ready_i)
            st_q <= dma_evt_pkg::ST_IDLE;
        default:
          st_q <= dma_evt_pkg::ST_IDLE;
      endcase
    end
  end

  assign svc_valid_o = (st_q == dma_evt_pkg::ST_OFFER);
  assign svc_ch_o    = pick_q;

  // null reload after the last request; a quick set re-triggers one cycle later
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      null_q    <= '0;
      qnull_q   <= '0;
      qreload_q <= '0;
    end
    else
    begin
      null_q    <= ((null_sub && !pick_q[`IDX_W-1]) ? code_bit(pick_q[`CODE_W-1:0]) : '0)
                 | null_q & ~set_write_i;
      qnull_q   <= ((null_sub && pick_q[`IDX_W-1]) ? q_pick_bit(pick_q) : '0)
                 | qnull_q & ~quick_set_write_i;
      qreload_q <= (null_sub && pick_q[`IDX_W-1]) ? q_pick_bit(pick_q) : '0;
    end
  end

  // pending bit index is the completion code, not the channel
  assign ipr_set = ((accept && sub_early_i && (sub_final_i ? sub_final_completion_irq_en_i : sub_intermediate_completion_irq_en_i))
                    ? code_bit(sub_code_i) : '0)
                 | ((cmp_valid_i && (cmp_final_i ? cmp_final_completion_irq_en_i : cmp_intermediate_completion_irq_en_i))
                    ? code_bit(cmp_code_i) : '0);
  assign ipr_clr = pending_clear_port_i
                 | (shd_wr_i ? (shd_pending_clear_i & shd_mask) : '0);

  // interrupts and status registered; one cycle behind the flags
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      cmp_irq_o         <= 1'b0;
      err_irq_o         <= 1'b0;
      cc_busy_o         <= 1'b0;
      pwr_idle_o        <= 1'b0;
      shd_event_latch_o <= '0;
      shd_pending_o     <= '0;
    end
    else
    begin
      cmp_irq_o         <= |(ipr_q & ier_q);
      err_irq_o         <= (|emr_q) | (|quick_missed_flags_q);
      cc_busy_o         <= any_elig || svc_valid_o;
      pwr_idle_o        <= !(any_elig || svc_valid_o) && !xfer_busy_i;
      shd_event_latch_o <= er_q & shd_mask;
      shd_pending_o     <= ipr_q & shd_mask;
    end
  end

  for (genvar r = 0; r < `REG_N; r++)
  begin : g_region
    always_ff @(posedge mclk_i)
    begin
      if (!rst_n_i)
        region_irq_o[r] <= 1'b0;
      else
        region_irq_o[r] <= |(ipr_q & ier_q & dma_region_access_mask_i[r]);
    end
  end

  assign hq.push   = accept && !sub_bypass_i;
  assign hq.ch     = pick_q;
  assign hq.rd_idx = hist_idx_i;
  assign hist_ch_o  = hq.rd_ch;
  assign hist_vld_o = hq.rd_vld;
  evt_history u_hist (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .h(hq.store));

  assign event_latch_o                = er_q;
  assign event_enable_mask_o          = eer_q;
  assign quick_channel_enable_mask_o  = quick_channel_enable_mask_q;
  assign secondary_event_flags_o      = ser_q;
  assign event_missed_flags_o         = emr_q;
  assign quick_secondary_flags_o      = quick_secondary_flags_q;
  assign quick_missed_flags_o         = quick_missed_flags_q;
  assign completion_pending_flags_o   = ipr_q;
  assign completion_irq_enable_mask_o = ier_q;

  chk_pick_enabled: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take |-> ((d_pick & ~(er_q & eer_q | trg_q)) == '0) && ((q_pick & ~quick_channel_enable_mask_q) == '0))
    else $error("service picked a disabled event");
  chk_ser_blocks: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(svc_valid_o) && !svc_ch_o[`IDX_W-1]
      |-> (($past(ser_q) & code_bit(svc_ch_o[`CODE_W-1:0])) == '0))
    else $error("service on a channel with secondary flag");
  chk_null_error: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    arr_err != '0 |=> ((ser_q & emr_q & $past(arr_err)) == $past(arr_err)))
    else $error("null trigger did not set error flags");
  chk_null_reload: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    null_sub && !svc_ch_o[`IDX_W-1] |=> null_q[$past(svc_ch_o[`CODE_W-1:0])])
    else $error("set not made null after last request");
  chk_quick_retrig: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    null_sub && svc_ch_o[`IDX_W-1] |=> qreload_q == $past(q_pick_bit(svc_ch_o)))
    else $error("quick null reload did not trigger");
  chk_pend_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_valid_i && cmp_final_i && cmp_final_completion_irq_en_i |=> ipr_q[$past(cmp_code_i)])
    else $error("completion code did not set pending bit");
  chk_early_cmp: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    accept && sub_early_i && !sub_final_i && sub_intermediate_completion_irq_en_i |=> ipr_q[$past(sub_code_i)])
    else $error("early completion not signalled at hand-off");
  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_irq_o |-> $past(|(ipr_q & ier_q)))
    else $error("completion irq without enabled pending bit");
  chk_region_irq: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    |(ipr_q & ier_q & dma_region_access_mask_i[1]) |=> region_irq_o[1])
    else $error("region irq missing");
  chk_latch_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ((er_q & ~$past(er_q)) | (~er_q & $past(er_q) & ~$past(er_clr))) == '0
      || $past(periph_evt_i) != '0)
    else $error("event latch changed without cause");
  chk_enable_ports: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (eer_q & ~$past(eer_q) & ~$past(enable_mask_set_port_i)) == '0)
    else $error("enable mask set without write-1");
  chk_err_irq: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    emr_q != '0 |=> err_irq_o)
    else $error("missed flag without error irq");
endmodule
`default_nettype wire

// file: verif/tc_model.sv
// transfer controller stand-in that takes offered requests after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module tc_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // request hand-off
  input  wire logic       svc_valid_i,
  input  wire logic [3:0] lag_i,
  output logic            svc_ready_o,
  output var int          taken_o
);
  logic [3:0] wait_q;
  // a nonzero lag holds the offer open so slow acceptance is exercised too
  assign svc_ready_o = svc_valid_i && (wait_q >= lag_i);
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wait_q  <= 4'h0;
      taken_o <= 0;
    end
    else if (svc_ready_o)
    begin
      wait_q  <= 4'h0;
      taken_o <= taken_o + 1;
    end
    else if (svc_valid_i)
      wait_q <= wait_q + 4'h1;
  end
endmodule
`default_nettype wire

// file: verif/dma_event_irq_ctl_tb.sv
// self-checking bench for the dma event and completion interrupt controller
`timescale 1ns/1ps
`default_nettype none
module dma_event_irq_ctl_tb;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, svc_ready_i, svc_valid_o, cmp_irq_o, err_irq_o;
  logic [31:0] periph_evt_i = '0, event_set_port_i = '0, event_latch_clear_port_i = '0;
  logic [31:0] enable_mask_set_port_i = '0, enable_mask_clear_port_i = '0, set_write_i = '0;
  logic [31:0] secondary_clear_i = '0, missed_clear_i = '0, pending_clear_port_i = '0;
  logic [31:0] irq_enable_set_i = '0, irq_enable_clear_i = '0, shd_event_set_i = '0;
  logic [31:0] shd_latch_clear_i = '0, shd_pending_clear_i = '0, event_latch_o;
  logic [31:0] event_enable_mask_o, secondary_event_flags_o, event_missed_flags_o;
  logic [31:0] completion_pending_flags_o;
  logic [31:0] shd_pending_o, completion_irq_enable_mask_o;
  logic [7:0] quick_channel_enable_mask_o, quick_secondary_flags_o, quick_missed_flags_o;
  logic pwr_idle_o, hist_vld_o;
  logic [5:0] hist_ch_o;
  logic [7:0] quick_enable_set_i = '0, quick_enable_clear_i = '0, quick_set_write_i = '0;
  logic [7:0] quick_secondary_clear_i = '0, quick_missed_clear_i = '0, shd_quick_enable_set_i = '0;
  logic [1:0][31:0] dma_region_access_mask_i = '0;
  logic [1:0][7:0] quick_region_access_mask_i = '0;
  logic shd_wr_i = 1'b0, shd_region_i = 1'b0, sub_keep_i = 1'b1, sub_early_i = 1'b1;
  logic sub_final_i = 1'b1, sub_final_completion_irq_en_i = 1'b0, sub_intermediate_completion_irq_en_i = 1'b0, sub_chain_en_i = 1'b0;
  logic sub_bypass_i = 1'b0, cmp_valid_i = 1'b0, cmp_final_i = 1'b0, cmp_final_completion_irq_en_i = 1'b0;
  logic cmp_intermediate_completion_irq_en_i = 1'b0, cmp_chain_en_i = 1'b0, xfer_busy_i = 1'b0;
  logic [15:0] sub_link_i = 16'h0000;
  logic [4:0] sub_code_i = 5'h00, cmp_code_i = 5'h00;
  logic [1:0] hist_idx_i = 2'h0, region_irq_o;
  logic [3:0] lag = 4'h0;
  int taken, t0, num_errors = 0, samples_checked = 0;
  dma_event_irq_ctl DUT (.mclk_i, .rst_n_i, .periph_evt_i, .event_set_port_i,
    .event_latch_clear_port_i, .enable_mask_set_port_i, .enable_mask_clear_port_i,
    .quick_enable_set_i, .quick_enable_clear_i, .secondary_clear_i, .missed_clear_i,
    .quick_secondary_clear_i, .quick_missed_clear_i, .irq_enable_set_i, .irq_enable_clear_i,
    .pending_clear_port_i, .set_write_i, .quick_set_write_i, .dma_region_access_mask_i,
    .quick_region_access_mask_i, .shd_wr_i, .shd_region_i, .shd_event_set_i,
    .shd_latch_clear_i, .shd_pending_clear_i, .shd_quick_enable_set_i, .shd_event_latch_o(),
    .shd_pending_o, .svc_valid_o, .svc_ch_o(), .svc_ready_i, .sub_keep_i, .sub_link_i,
    .sub_early_i, .sub_final_i, .sub_final_completion_irq_en_i, .sub_intermediate_completion_irq_en_i, .sub_chain_en_i, .sub_code_i,
    .sub_bypass_i, .cmp_valid_i, .cmp_final_i, .cmp_final_completion_irq_en_i, .cmp_intermediate_completion_irq_en_i,
    .cmp_chain_en_i, .cmp_code_i, .xfer_busy_i, .event_latch_o, .event_enable_mask_o,
    .quick_channel_enable_mask_o, .secondary_event_flags_o, .event_missed_flags_o,
    .quick_secondary_flags_o, .quick_missed_flags_o, .completion_pending_flags_o,
    .completion_irq_enable_mask_o, .cmp_irq_o, .region_irq_o, .err_irq_o, .cc_busy_o(),
    .pwr_idle_o, .hist_idx_i, .hist_ch_o, .hist_vld_o);
  tc_model PARTNER (.mclk_i, .rst_n_i, .svc_valid_i(svc_valid_o), .lag_i(lag),
    .svc_ready_o(svc_ready_i), .taken_o(taken));
  initial
    forever #25 mclk_i = ~mclk_i;
  task automatic pulse(ref logic [31:0] s, input logic [31:0] v);
    @(negedge mclk_i) s = v;
    @(negedge mclk_i) s = '0;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the partner to take one request
  task wait_take();
    t0 = taken;
    for (int i = 0; i < 20 && taken == t0; i++)
      @(negedge mclk_i);
    if (taken == t0)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  task masks_and_latch();
    pulse(enable_mask_set_port_i, 32'h0000_0008);
    chk("enable mask", 32'h0000_0008, event_enable_mask_o);
    pulse(enable_mask_clear_port_i, 32'h0000_0000);
    chk("enable mask", 32'h0000_0008, event_enable_mask_o);
    t0 = taken;
    pulse(periph_evt_i, 32'h0000_0020);
    repeat (4) @(negedge mclk_i);
    chk("latch", 32'h0000_0020, event_latch_o);
    chk("taken", t0, taken);
    pulse(event_latch_clear_port_i, 32'h0000_0000);
    chk("latch", 32'h0000_0020, event_latch_o);
    pulse(event_latch_clear_port_i, 32'h0000_0020);
    chk("latch", 32'h0000_0000, event_latch_o);
    pulse(enable_mask_clear_port_i, 32'h0000_0008);
    chk("enable mask", 32'h0000_0000, event_enable_mask_o);
  endtask
  task completion();
    pulse(irq_enable_set_i, 32'h8000_0000);
    sub_code_i = 5'h1F;
    sub_final_completion_irq_en_i = 1'b1;
    pulse(event_set_port_i, 32'h0000_0001);
    wait_take();
    chk("pending", 32'h8000_0000, completion_pending_flags_o);
    @(negedge mclk_i);
    chk("cmp irq", 1, cmp_irq_o);
    pulse(pending_clear_port_i, 32'h8000_0000);
    chk("pending", 32'h0000_0000, completion_pending_flags_o);
    sub_code_i = 5'h1E;
    pulse(event_set_port_i, 32'h0000_0001);
    wait_take();
    @(negedge mclk_i);
    chk("cmp irq", 0, cmp_irq_o);
    pulse(irq_enable_set_i, 32'h4000_0000);
    chk("irq enable", 32'hC000_0000, completion_irq_enable_mask_o);
    dma_region_access_mask_i = {32'h4000_0000, 32'h4000_0000};
    repeat (2) @(negedge mclk_i);
    chk("region irq", 2'h3, region_irq_o);
    dma_region_access_mask_i[1] = 32'h0000_0000;
    repeat (2) @(negedge mclk_i);
    chk("region irq", 2'h1, region_irq_o);
    sub_code_i = 5'h1D;
    sub_final_completion_irq_en_i = 1'b0;
    pulse(event_set_port_i, 32'h0000_0001);
    wait_take();
    chk("pending", 32'h4000_0000, completion_pending_flags_o);
  endtask
  task null_set();
    lag = 4'h3;
    sub_keep_i = 1'b0;
    sub_link_i = 16'hFFFF;
    pulse(event_set_port_i, 32'h0000_0002);
    wait_take();
    sub_keep_i = 1'b1;
    sub_link_i = 16'h0000;
    pulse(event_set_port_i, 32'h0000_0002);
    chk("secondary", 32'h0000_0002, secondary_event_flags_o);
    chk("missed", 32'h0000_0002, event_missed_flags_o);
    @(negedge mclk_i);
    chk("err irq", 1, err_irq_o);
    t0 = taken;
    pulse(set_write_i, 32'h0000_0002);
    pulse(event_set_port_i, 32'h0000_0002);
    repeat (8) @(negedge mclk_i);
    chk("taken", t0, taken);
    pulse(missed_clear_i, 32'h0000_0002);
    pulse(secondary_clear_i, 32'h0000_0002);
    chk("missed", 32'h0000_0000, event_missed_flags_o);
    wait_take();
  endtask
  // cmp chains to 27 (final irq), 27 completes early on 28; then a bypassed quick null reload
  task chain_quick();
    sub_final_i = 1'b0;
    sub_intermediate_completion_irq_en_i = 1'b1;
    sub_code_i = 5'h1C;
    {cmp_valid_i, cmp_final_i, cmp_final_completion_irq_en_i, cmp_chain_en_i, cmp_code_i} = {4'hF, 5'h1B};
    @(negedge mclk_i) cmp_valid_i = 1'b0;
    wait_take();
    chk("pending", 32'h5800_0000, completion_pending_flags_o);
    @(negedge mclk_i);
    chk("shadow pending", 32'h4000_0000, shd_pending_o);
    {shd_wr_i, shd_pending_clear_i} = {1'b1, 32'h4800_0000};
    @(negedge mclk_i) shd_wr_i = 1'b0;
    chk("pending", 32'h1800_0000, completion_pending_flags_o);
    {sub_keep_i, sub_link_i, sub_bypass_i} = {1'b0, 16'hFFFF, 1'b1};
    quick_enable_set_i = 8'h04;
    @(negedge mclk_i) {quick_enable_set_i, quick_set_write_i} = {8'h00, 8'h0C};
    @(negedge mclk_i) quick_set_write_i = 8'h00;
    wait_take();
    repeat (4) @(negedge mclk_i);
    chk("taken", t0 + 1, taken);
    chk("quick mask", 32'h04, quick_channel_enable_mask_o);
    chk("quick secondary", 32'h04, quick_secondary_flags_o);
    chk("quick missed", 32'h04, quick_missed_flags_o);
    {sub_keep_i, sub_link_i, sub_bypass_i, hist_idx_i} = {1'b1, 16'h0000, 1'b0, 2'h1};
    @(negedge mclk_i) hist_idx_i = 2'h2;
    chk("history", 32'h1B, hist_ch_o);
    @(negedge mclk_i);
    chk("history", 32'h00, hist_ch_o);
    chk("history valid", 1, hist_vld_o);
    chk("power idle", 1, pwr_idle_o);
    xfer_busy_i = 1'b1;
    @(negedge mclk_i);
    chk("power idle", 0, pwr_idle_o);
  endtask
  initial
  begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    pulse(set_write_i, 32'hFFFF_FFFF);
    masks_and_latch();
    completion();
    null_set();
    chain_quick();
    stop_test();
  end
endmodule
`default_nettype wire
